/* File: shared/brc_pkg.sv */
// shared constants and types of the bcd clock core
package brc_pkg;
  // address map of the byte-wide space
  localparam int unsigned ADDR_W = 13;
  localparam logic [12:0] CTRL_ADDR = 13'h1ff8;
  localparam logic [12:0] SEC_ADDR = 13'h1ff9;

  // rates of the core clock and the crystal timebase
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  localparam int unsigned OSC_DIV_DEF = (CLK_HZ + OSC_HZ / 2) / OSC_HZ;

  // divider chain and calibration amounts, in crystal cycles
  localparam logic [15:0] SEC_CYCLES = 16'h8000;
  localparam logic [15:0] CAL_SHORT = 16'h0100;
  localparam logic [15:0] CAL_LONG = 16'h0080;
  localparam int unsigned TEST_BIT = 5;
  localparam logic [4:0] TEST_LOW = 5'h1f;
  localparam logic [5:0] CAL_MINUTES = 6'h3e;

  // control register fields
  localparam int unsigned CTRL_WRITE = 7;
  localparam int unsigned CTRL_READ = 6;
  localparam int unsigned CTRL_SIGN = 5;
  localparam int unsigned CAL_W = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // flag bits living inside the seconds and weekday registers
  localparam int unsigned STOP_BIT = 7;
  localparam int unsigned TEST_EN_BIT = 6;
  localparam logic [7:0] STOP_MASK = 8'h80;
  localparam logic [7:0] TEST_EN_MASK = 8'h40;
  localparam logic STOP_RST = 1'b1;

  // time field indices, index 0 sits at the seconds address
  localparam int unsigned T_SEC = 0;
  localparam int unsigned T_HOUR = 2;
  localparam int unsigned T_DAY = 3;
  localparam int unsigned T_DATE = 4;
  localparam int unsigned T_MON = 5;
  localparam int unsigned T_YEAR = 6;
  localparam int unsigned T_NUM = 7;

  // per-field writable bits, upper and lower limits, year first
  localparam logic [6:0][7:0] TIME_MASK =
    {8'hff, 8'h1f, 8'h3f, 8'h07, 8'h3f, 8'h7f, 8'h7f};
  localparam logic [6:0][7:0] TIME_MAX =
    {8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h59};
  localparam logic [6:0][7:0] TIME_MIN =
    {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

  // bus activity seen on the pins
  typedef enum logic [1:0] {
    BRC_IDLE = 2'b00,
    BRC_READ = 2'b01,
    BRC_WRITE = 2'b10
  } brc_bus_e;

  // one host write, latched while the write strobe is low
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] data;
  } brc_wreq_s;
endpackage : brc_pkg

/* File: core/brc_sram.sv */
// byte-wide static memory with registered read data
module brc_sram #(
  parameter int unsigned AW = 13,
  parameter int unsigned DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_reg
);
  logic [DW-1:0] mem [2**AW];

  if (AW < 1 || AW > 20 || DW < 1) begin : g_bad_size
    $error("brc_sram size out of range");
  end

  // storage array, no reset
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // read data register
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_reg <= '0;
    else
      rdata_reg <= mem[raddr];
  end
endmodule : brc_sram

/* File: core/brc_rtc_core.sv */
// bcd clock core: counters, host time registers and sram on a byte bus
//
// Contract
// - read hold bit stops register refresh
// - frozen registers show time at halt
// - all registers refresh together, atomically
// - refresh resumes within a second
// - counters keep running while registers frozen
// - set hold bit also halts refresh
// - set hold release loads counters from registers
// - stop bit halts the oscillator
// - stop bit starts out set
// - oscillator runs within one second of clear
// - 32768 Hz timebase divided to seconds
// - calibration adds or removes divider counts
// - five-bit calibration magnitude, 0 to 31
// - sign bit one adds, zero removes
// - 64-minute cycle, one second adjusted
// - magnitude N adjusts first 2N minutes
// - test bit toggles seconds lsb at 512 Hz
// - calibration leaves test frequency alone
module brc_rtc_core #(
  parameter int unsigned OSC_DIV = brc_pkg::OSC_DIV_DEF
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // sram style host bus
  input wire logic [brc_pkg::ADDR_W-1:0] ADDR,
  input wire logic E1_N,
  input wire logic E2,
  input wire logic G_N,
  input wire logic W_N,
  // data lines split into in, out and enable
  input wire logic [7:0] DQ_IN,
  output logic [7:0] DQ_OUT,
  output logic DQ_OE_N
);
  localparam logic [15:0] DIV_LAST = 16'(OSC_DIV - 1);

  if (OSC_DIV < 2 || OSC_DIV > 65535) begin : g_bad_div
    $error("OSC_DIV out of range");
  end

  brc_pkg::brc_bus_e bus_reg, bus_next, bus_want;
  brc_pkg::brc_wreq_s wreq_reg, wreq_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic stop_reg, stop_next, tst_en_reg, tst_en_next;
  logic [6:0][7:0] cnt_reg, cnt_next, cnt_adv, vis_reg, vis_next;
  logic [15:0] osc_cnt_reg, osc_cnt_next, pre_cnt_reg, pre_cnt_next;
  logic [5:0] free_reg, free_next, min_idx_reg, min_idx_next;
  logic upd_reg;
  logic [12:0] rd_addr_reg;
  logic [7:0] mem_rdata;
  logic [7:0] carry;

  // bcd increment of one field, no limit check
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
    else
      bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction : bcd_inc

  // last date of the month, leap years by the two year digits
  function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02: month_len = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction : month_len

  // pin decode, pins are synchronous to the core clock
  wire sel = !E1_N && E2;
  assign bus_want = !sel ? brc_pkg::BRC_IDLE
                  : !W_N ? brc_pkg::BRC_WRITE
                  : !G_N ? brc_pkg::BRC_READ : brc_pkg::BRC_IDLE;

  // bus state machine, a write commits when its strobe ends
  always_comb
  begin
    case (bus_reg)
      brc_pkg::BRC_IDLE: bus_next = bus_want;
      brc_pkg::BRC_READ: bus_next = bus_want;
      brc_pkg::BRC_WRITE: bus_next = bus_want;
      default: bus_next = brc_pkg::BRC_IDLE;
    endcase
  end

  // write capture and target decode
  assign wreq_next = (bus_next == brc_pkg::BRC_WRITE) ? '{addr: ADDR, data: DQ_IN} : wreq_reg;
  wire wr_commit = bus_reg == brc_pkg::BRC_WRITE && bus_next != brc_pkg::BRC_WRITE;
  wire clk_space = wreq_reg.addr >= brc_pkg::CTRL_ADDR;
  wire mem_we = wr_commit && !clk_space;
  wire ctrl_wr = wr_commit && wreq_reg.addr == brc_pkg::CTRL_ADDR;
  wire time_wr = wr_commit && clk_space && !ctrl_wr;
  wire [2:0] wr_idx = 3'(wreq_reg.addr - brc_pkg::SEC_ADDR);
  wire [7:0] wdata = wreq_reg.data;

  // hold bits and the two release events
  wire hold = ctrl_reg[brc_pkg::CTRL_WRITE] | ctrl_reg[brc_pkg::CTRL_READ];
  wire set_release = ctrl_wr && ctrl_reg[brc_pkg::CTRL_WRITE]
                     && !wdata[brc_pkg::CTRL_WRITE];
  wire hold_release = ctrl_wr && hold && !wdata[brc_pkg::CTRL_WRITE]
                      && !wdata[brc_pkg::CTRL_READ];

  // control byte and flag bits; stop may be written at any time
  assign ctrl_next = ctrl_wr ? wdata : ctrl_reg;
  assign stop_next = (time_wr && wr_idx == 3'(brc_pkg::T_SEC))
                     ? wdata[brc_pkg::STOP_BIT] : stop_reg;
  assign tst_en_next = (time_wr && wr_idx == 3'(brc_pkg::T_DAY))
                       ? wdata[brc_pkg::TEST_EN_BIT] : tst_en_reg;

  // crystal rate enable from the core clock, halted by stop
  wire osc_wrap = osc_cnt_reg >= DIV_LAST;
  wire osc_tick = !stop_reg && osc_wrap;
  assign osc_cnt_next = (stop_reg || osc_wrap) ? 16'h0000
                        : 16'(osc_cnt_reg + 16'h0001);

  // free divider for the test output, untouched by calibration
  assign free_next = osc_tick ? 6'(free_reg + 6'h01) : free_reg;
  wire test_bit = free_reg[brc_pkg::TEST_BIT];

  // calibration window: first 2n minutes, first second of each
  wire [4:0] cal_mag = ctrl_reg[brc_pkg::CAL_W-1:0];
  wire cal_min = min_idx_reg < {cal_mag, 1'b0};
  wire cal_now = cal_min && cnt_reg[brc_pkg::T_SEC] == brc_pkg::TIME_MIN[brc_pkg::T_SEC];

  // second length: positive splits pulses, negative blanks them
  wire [15:0] sec_len = !cal_now ? brc_pkg::SEC_CYCLES
                      : ctrl_reg[brc_pkg::CTRL_SIGN]
                        ? 16'(brc_pkg::SEC_CYCLES - brc_pkg::CAL_SHORT)
                        : 16'(brc_pkg::SEC_CYCLES + brc_pkg::CAL_LONG);
  wire pre_wrap = pre_cnt_reg >= 16'(sec_len - 16'h0001);
  wire sec_tick = osc_tick && pre_wrap;

  // prescaler restarts when new time is loaded
  always_comb
  begin
    if (set_release)
      pre_cnt_next = 16'h0000;
    else if (osc_tick)
      pre_cnt_next = pre_wrap ? 16'h0000 : 16'(pre_cnt_reg + 16'h0001);
    else
      pre_cnt_next = pre_cnt_reg;
  end

  // minute index within the 64-minute calibration cycle
  assign min_idx_next = carry[1] ? 6'(min_idx_reg + 6'h01) : min_idx_reg;

  // bcd counter chain; the date follows the hour, not the weekday
  wire [7:0] days_lim = month_len(cnt_reg[brc_pkg::T_MON], cnt_reg[brc_pkg::T_YEAR]);
  assign carry[0] = sec_tick;
  for (genvar i = 0; i < brc_pkg::T_NUM; i++) begin : g_field
    wire [7:0] lim = (i == brc_pkg::T_DATE) ? days_lim : brc_pkg::TIME_MAX[i];
    wire cin = (i == brc_pkg::T_DATE) ? carry[brc_pkg::T_DAY] : carry[i];
    wire at_lim = cnt_reg[i] >= lim;
    assign carry[i+1] = cin && at_lim;
    assign cnt_adv[i] = !cin ? cnt_reg[i]
                        : at_lim ? brc_pkg::TIME_MIN[i] : bcd_inc(cnt_reg[i]);

    // visible register: host write, else atomic copy when not held
    assign vis_next[i] = (time_wr && wr_idx == 3'(i)) ? (wdata & brc_pkg::TIME_MASK[i])
                       : (upd_reg && !hold) ? cnt_reg[i]
                       : vis_reg[i];
  end

  // counters advance regardless of hold, load on set release
  assign cnt_next = set_release ? vis_reg : cnt_adv;

  // bus state, write latch and control flops
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      bus_reg <= brc_pkg::BRC_IDLE;
      wreq_reg <= '0;
      ctrl_reg <= brc_pkg::CTRL_RST;
      stop_reg <= brc_pkg::STOP_RST;
      tst_en_reg <= 1'b0;
    end
    else
    begin
      bus_reg <= bus_next;
      wreq_reg <= wreq_next;
      ctrl_reg <= ctrl_next;
      stop_reg <= stop_next;
      tst_en_reg <= tst_en_next;
    end
  end

  // timebase dividers
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      osc_cnt_reg <= 16'h0000;
      pre_cnt_reg <= 16'h0000;
      free_reg <= 6'h00;
      min_idx_reg <= 6'h00;
    end
    else
    begin
      osc_cnt_reg <= osc_cnt_next;
      pre_cnt_reg <= pre_cnt_next;
      free_reg <= free_next;
      min_idx_reg <= min_idx_next;
    end
  end

  // time counters, visible registers and update pulse
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      cnt_reg <= brc_pkg::TIME_MIN;
      vis_reg <= brc_pkg::TIME_MIN;
      upd_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      vis_reg <= vis_next;
      upd_reg <= sec_tick || hold_release;
    end
  end

  // ordinary memory below the clock registers
  brc_sram #(
    .AW(brc_pkg::ADDR_W),
    .DW(8)
  ) u_sram (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .we(mem_we),
    .waddr(wreq_reg.addr),
    .wdata(wdata),
    .raddr(ADDR),
    .rdata_reg(mem_rdata)
  );

  // read view of the clock registers
  wire [2:0] rd_idx = 3'(rd_addr_reg - brc_pkg::SEC_ADDR);
  wire rd_clk = rd_addr_reg >= brc_pkg::CTRL_ADDR;
  wire rd_ctrl = rd_addr_reg == brc_pkg::CTRL_ADDR;
  wire test_on = tst_en_reg && !stop_reg;
  wire [7:0] sec_vis = vis_reg[brc_pkg::T_SEC];
  wire [7:0] sec_view = {sec_vis[7:1], test_on ? test_bit : sec_vis[0]}
                        | (stop_reg ? brc_pkg::STOP_MASK : 8'h00);
  wire [7:0] day_view = vis_reg[brc_pkg::T_DAY] | (tst_en_reg ? brc_pkg::TEST_EN_MASK : 8'h00);
  wire [7:0] time_view = (rd_idx == 3'(brc_pkg::T_SEC)) ? sec_view
                       : (rd_idx == 3'(brc_pkg::T_DAY)) ? day_view : vis_reg[rd_idx];
  wire [7:0] reg_view = rd_ctrl ? ctrl_reg : time_view;

  // data line drivers, two cycles behind the pins
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      rd_addr_reg <= 13'h0000;
      DQ_OUT <= 8'h00;
      DQ_OE_N <= 1'b1;
    end
    else
    begin
      rd_addr_reg <= ADDR;
      DQ_OUT <= rd_clk ? reg_view : mem_rdata;
      DQ_OE_N <= bus_reg != brc_pkg::BRC_READ;
    end
  end

  // checks
  default clocking a_cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_copy_done;
    upd_reg ##1 vis_reg == $past(cnt_reg);
  endsequence

  sequence s_load_done;
    upd_reg && cnt_reg == $past(vis_reg);
  endsequence

  a_hold_freeze: assert property (hold && !time_wr |=> vis_reg == $past(vis_reg))
    else $error("visible time moved while held");

  a_set_hold: assert property (ctrl_reg[brc_pkg::CTRL_WRITE] && !time_wr |=> $stable(vis_reg))
    else $error("visible time moved while set hold");

  a_upd_copy: assert property (upd_reg && !hold && !time_wr |=> vis_reg == $past(cnt_reg))
    else $error("update did not copy all counters");

  a_hold_resume: assert property (hold_release |=> s_copy_done)
    else $error("refresh did not resume after release");

  a_count_runs: assert property (sec_tick && !set_release |=> cnt_reg != $past(cnt_reg))
    else $error("counters did not advance");

  a_set_load: assert property (set_release |=> s_load_done)
    else $error("counters not loaded on set release");

  a_stop_halt: assert property (stop_reg |=> free_reg == $past(free_reg) && !osc_tick)
    else $error("oscillator ran while stopped");

  a_stop_reset: assert property ($past(SYS_RST) |-> stop_reg)
    else $error("stop bit clear after reset");

  a_osc_run: assert property (!stop_reg && !osc_wrap |=> osc_cnt_reg == $past(osc_cnt_reg) + 16'h0001)
    else $error("oscillator divider not running");

  a_cal_window: assert property (cal_now |-> (min_idx_reg >> 1) < cal_mag && min_idx_reg < brc_pkg::CAL_MINUTES)
    else $error("calibration outside its minutes");

  a_test_rate: assert property ($changed(test_bit) |-> $past(osc_tick) && $past(free_reg[4:0]) == brc_pkg::TEST_LOW)
    else $error("test output toggled off its rate");
endmodule : brc_rtc_core

/* File: verification/brc_host_model.sv */
// host processor model driving the byte-wide bus of the clock core
module brc_host_model (
  // clock
  input wire logic clk,
  // bus pins toward the core
  output logic [12:0] addr,
  output logic e1_n,
  output logic e2,
  output logic g_n,
  output logic w_n,
  output logic [7:0] dq_in,
  // read answer from the core
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero, nothing selected
  initial
  begin
    addr = 13'h0000;
    e1_n = 1'b1;
    e2 = 1'b0;
    g_n = 1'b1;
    w_n = 1'b1;
    dq_in = 8'h00;
  end

  // one write: strobe low for one edge, then released with the select
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    dq_in <= d;
    e1_n <= 1'b0;
    e2 <= 1'b1;
    g_n <= 1'b1;
    w_n <= 1'b0;
    @(posedge clk);
    w_n <= 1'b1;
    e1_n <= 1'b1;
    // data held through the commit edge, then scrambled
    @(posedge clk);
    addr <= ~a;
    dq_in <= ~d;
    @(posedge clk);
  endtask : wr

  // open a read and keep it open, no read hold needed
  task automatic rd_start(input logic [12:0] a);
    @(posedge clk);
    addr <= a;
    e1_n <= 1'b0;
    e2 <= 1'b1;
    g_n <= 1'b1 ^ 1'b1;
    w_n <= 1'b1;
  endtask : rd_start

  // close a read; the address no longer shows the old value
  task automatic rd_stop();
    @(posedge clk);
    g_n <= 1'b1;
    e2 <= 1'b0;
    addr <= ~addr;
  endtask : rd_stop

  // single read, sampled once the two-edge pipeline has settled
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic oe_n);
    rd_start(a);
    repeat (4) @(posedge clk);
    #1;
    d = dq_out;
    oe_n = dq_oe_n;
    rd_stop();
  endtask : rd
endmodule : brc_host_model

/* File: verification/bcd_rtc_update_and_calibration_bench.sv */
// self-checking bench of the bcd clock core
module bcd_rtc_update_and_calibration_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SEC_CYC = 65536; // one second with a divider of 2
  localparam int TEST_GAP = 64; // cycles between test wave edges
  typedef struct {
    logic wr;
    logic [12:0] a;
    logic [7:0] d;
    logic [7:0] exp;
  } brc_row_s;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [12:0] addr;
  logic e1_n;
  logic e2;
  logic g_n;
  logic w_n;
  logic [7:0] dq_in;
  logic [7:0] dq_out;
  logic dq_oe_n;
  int error_cnt = 0;
  int checked = 0;
  int ntog;
  int gap;

  // reset reads, then set-time writes under the set hold
  brc_row_s rows [19] = '{
    '{1'b0, brc_pkg::CTRL_ADDR, 8'h00, 8'h00}, '{1'b0, brc_pkg::SEC_ADDR, 8'h00, 8'h80},
    '{1'b0, 13'h1ffa, 8'h00, 8'h00}, '{1'b0, 13'h1ffb, 8'h00, 8'h00},
    '{1'b0, 13'h1ffc, 8'h00, 8'h01}, '{1'b0, 13'h1ffd, 8'h00, 8'h01},
    '{1'b0, 13'h1ffe, 8'h00, 8'h01}, '{1'b0, 13'h1fff, 8'h00, 8'h00},
    '{1'b1, brc_pkg::CTRL_ADDR, 8'h80, 8'h80}, '{1'b1, 13'h0000, 8'ha5, 8'ha5},
    '{1'b1, 13'h1ff7, 8'h5a, 8'h5a}, '{1'b1, 13'h1ffa, 8'hff, 8'h7f},
    '{1'b1, 13'h1ffa, 8'h59, 8'h59}, '{1'b1, 13'h1ffb, 8'h23, 8'h23},
    '{1'b1, 13'h1ffc, 8'h07, 8'h07}, '{1'b1, 13'h1ffd, 8'h31, 8'h31},
    '{1'b1, 13'h1ffe, 8'h12, 8'h12}, '{1'b1, 13'h1fff, 8'h99, 8'h99},
    '{1'b1, brc_pkg::SEC_ADDR, 8'h58, 8'h58}};

  // core clock, 5 ns period
  always #2.5 clk = ~clk;

  // design and host model
  brc_rtc_core #(.OSC_DIV(2)) uut (.CORE_CLK(clk), .SYS_RST(sys_rst), .ADDR(addr),
    .E1_N(e1_n), .E2(e2), .G_N(g_n), .W_N(w_n), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE_N(dq_oe_n));
  brc_host_model host (.clk(clk), .addr(addr), .e1_n(e1_n), .e2(e2), .g_n(g_n), .w_n(w_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // read one byte and compare it, output enable included
  task automatic rdchk(input logic [12:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic oe_n;
    host.rd(a, d, oe_n);
    chk(d, exp, what);
    chk({7'h00, oe_n}, 8'h00, "read output enable");
  endtask : rdchk

  // extended seconds read, counting edges of the lsb and the last spacing
  task automatic measure(output int nt, output int gp);
    int t;
    int tlast;
    logic prev;
    nt = 0;
    gp = 0;
    tlast = 0;
    host.rd_start(brc_pkg::SEC_ADDR);
    repeat (4) @(posedge clk);
    #1;
    prev = dq_out[0];
    for (t = 0; t < 300; t++)
    begin
      @(posedge clk);
      #1;
      if (dq_out[0] !== prev)
      begin
        nt++;
        if (nt > 1)
          gp = t - tlast;
        tlast = t;
        prev = dq_out[0];
      end
    end
    host.rd_stop();
  endtask : measure

  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        host.wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].exp, "table row");
    end
    $display("register table done");
    host.wr(brc_pkg::CTRL_ADDR, 8'h00);
    host.wr(brc_pkg::CTRL_ADDR, 8'h40);
    rdchk(brc_pkg::SEC_ADDR, 8'h58, "loaded seconds");
    repeat (SEC_CYC + 500) @(posedge clk);
    rdchk(brc_pkg::SEC_ADDR, 8'h58, "frozen seconds");
    rdchk(13'h1ffa, 8'h59, "frozen minutes");
    host.wr(brc_pkg::CTRL_ADDR, 8'h00);
    rdchk(brc_pkg::SEC_ADDR, 8'h59, "resumed seconds");
    rdchk(13'h1ffb, 8'h23, "hours after resume");
    $display("hold and resume done");
    host.wr(brc_pkg::CTRL_ADDR, 8'h80);
    host.wr(13'h1ffc, 8'h47);
    host.wr(brc_pkg::CTRL_ADDR, 8'h3f);
    rdchk(13'h1ffc, 8'h47, "weekday with test bit");
    measure(ntog, gap);
    chk(8'(gap), 8'(TEST_GAP), "test wave spacing");
    host.wr(brc_pkg::SEC_ADDR, 8'h80);
    measure(ntog, gap);
    chk(8'(ntog), 8'h00, "stopped test wave");
    host.wr(brc_pkg::CTRL_ADDR, 8'h1f);
    host.wr(brc_pkg::SEC_ADDR, 8'h00);
    measure(ntog, gap);
    chk(8'(ntog > 3), 8'h01, "restarted test wave");
    chk(8'(gap), 8'(TEST_GAP), "spacing with slow trim");
    $display("test wave done");
    summarize();
  end

  // watchdog against a hung sequence
  initial
  begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : bcd_rtc_update_and_calibration_bench
